// >>> tsf_map.svh
`ifndef TSF_MAP_SVH
`define TSF_MAP_SVH
`define TSF_CLK_HZ 125000000
`define TSF_BAUD 57600
`define TSF_BIT_CYC (`TSF_CLK_HZ / `TSF_BAUD)
`define TSF_HALF_CYC (`TSF_BIT_CYC / 2)
`define TSF_DATA_BITS 8
`define TSF_CHR_LF 8'h0a
`define TSF_CHR_CR 8'h0d
`define TSF_CHR_COMMA 8'h2c
`define TSF_CHR_QUERY 8'h3f
`define TSF_CRC_INIT 8'h00
`define TSF_CRC_POLY 8'h18
`define TSF_CRC_MASK 8'h7f
`define TSF_CRC_TOP 8'h80
`define TSF_NAME_LEN 3
`define TSF_PERIOD_CYC 32'd125000000
`endif

// >>> tsf_pkg.sv
package tsf_pkg;
	typedef logic [7:0] tsf_byte_type;
	typedef logic [23:0] tsf_name_type;
	// Gray codes along the usual path
	typedef enum logic [2:0]
	{
		TSF_IDLE = 3'h0,
		TSF_START = 3'h1,
		TSF_DATA = 3'h3,
		TSF_STOP = 3'h2
	} tsf_uart_type;
	typedef enum logic [2:0]
	{
		TSF_TX_IDLE = 3'h0,
		TSF_TX_BODY = 3'h1,
		TSF_TX_HI = 3'h3,
		TSF_TX_LO = 3'h2,
		TSF_TX_CR = 3'h6,
		TSF_TX_LF = 3'h7
	} tsf_txseq_type;
endpackage : tsf_pkg

// >>> tsf_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tsf_link_if;
	logic devToHost;
	logic hostToDev;
	modport devEnd (output devToHost, input hostToDev);
	modport hostEnd (input devToHost, output hostToDev);
endinterface : tsf_link_if
`default_nettype wire

// >>> tsf_device.sv
`include "tsf_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tsf_device
(
	// System
	input wire logic clock,
	input wire logic rst,
	// Link
	tsf_link_if.devEnd link,
	// Sentence to send: body is name, fields and final comma
	input wire tsf_pkg::tsf_byte_type txByte,
	input wire logic txValid,
	input wire logic txLast,
	output logic txReady,
	// Name polling support (one pollable name)
	input wire tsf_pkg::tsf_name_type pollName,
	// Events
	output logic requestSeen,
	output tsf_pkg::tsf_name_type requestName,
	output logic periodicTick,
	output logic frameError,
	output logic crcError,
	// Received sentence bytes of every line, passed on before the line check
	output tsf_pkg::tsf_byte_type rxByte,
	output logic rxValid,
	output logic rxEnd
);
	import tsf_pkg::*;

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	function automatic tsf_byte_type crcStep(input tsf_byte_type c, input tsf_byte_type d);
		tsf_byte_type r;
		logic fb;
		r = c;
		for (int i = 0; i < `TSF_DATA_BITS; i++)
		begin
			fb = r[0] ^ d[i];
			if (fb)
				r = r ^ `TSF_CRC_POLY;
			r = (r >> 1) & `TSF_CRC_MASK;
			if (fb)
				r = r | `TSF_CRC_TOP;
		end
		return r;
	endfunction : crcStep

	function automatic tsf_byte_type hexChr(input logic [3:0] n);
		return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction : hexChr

	function automatic logic [4:0] hexVal(input tsf_byte_type c);
		if (c >= 8'h30 && c <= 8'h39)
			return {1'b1, c[3:0]};
		if (c >= 8'h41 && c <= 8'h46)
			return {1'b1, c[3:0] + 4'h9};
		return 5'h00;
	endfunction : hexVal

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		logic rxMeta;
		logic rxSync;
		tsf_uart_type rxSt;
		logic [11:0] rxCnt;
		logic [2:0] rxBit;
		tsf_byte_type rxShift;
		tsf_byte_type rxCrc;
		tsf_byte_type prev1;
		tsf_byte_type prev2;
		tsf_byte_type crcAt1;
		tsf_byte_type crcAt2;
		logic [7:0] lineLen;
		logic [1:0] commaCnt;
		logic inName;
		tsf_name_type name;
		logic [7:0] afterFirst;
		logic queryField;
		logic reqPend;
		tsf_name_type reqName;
		tsf_uart_type txSt;
		logic [11:0] txCnt;
		logic [2:0] txBit;
		logic [8:0] txShift;
		logic txLine;
		tsf_txseq_type seq;
		tsf_byte_type txCrc;
		logic [1:0] bufCnt;
		tsf_byte_type buf0;
		tsf_byte_type buf1;
		logic bufL0;
		logic bufL1;
		logic [31:0] perCnt;
		logic requestSeen;
		tsf_name_type requestName;
		logic periodicTick;
		logic frameError;
		logic crcError;
		logic txReady;
		tsf_byte_type rxByte;
		logic rxValid;
		logic rxEnd;
	} tsf_dev_type;

	tsf_dev_type st_ff;
	tsf_dev_type nxt_st;
	tsf_byte_type newByte;
	logic gotByte;
	logic [4:0] hHi;
	logic [4:0] hLo;

	always_comb
	begin
		nxt_st = st_ff;
		newByte = st_ff.rxShift;
		gotByte = 1'b0;
		hHi = hexVal(st_ff.prev2);
		hLo = hexVal(st_ff.prev1);
		nxt_st.rxMeta = link.hostToDev;
		nxt_st.rxSync = st_ff.rxMeta;
		nxt_st.requestSeen = 1'b0;
		nxt_st.periodicTick = 1'b0;
		nxt_st.frameError = 1'b0;
		nxt_st.crcError = 1'b0;
		nxt_st.rxValid = 1'b0;
		nxt_st.rxEnd = 1'b0;

		// ----------------------------------------
		// Receiver
		// ----------------------------------------
		// 8N1 sampling at link rate
		unique case (st_ff.rxSt)
			TSF_IDLE:
				if (!st_ff.rxSync)
				begin
					nxt_st.rxSt = TSF_START;
					nxt_st.rxCnt = 12'(`TSF_HALF_CYC);
				end
			TSF_START:
				if (st_ff.rxCnt == 12'h0)
				begin
					nxt_st.rxSt = st_ff.rxSync ? TSF_IDLE : TSF_DATA;
					nxt_st.rxCnt = 12'(`TSF_BIT_CYC - 1);
					nxt_st.rxBit = 3'h0;
				end
				else
					nxt_st.rxCnt = st_ff.rxCnt - 12'h1;
			TSF_DATA:
				if (st_ff.rxCnt == 12'h0)
				begin
					nxt_st.rxShift = {st_ff.rxSync, st_ff.rxShift[7:1]};
					nxt_st.rxCnt = 12'(`TSF_BIT_CYC - 1);
					nxt_st.rxBit = st_ff.rxBit + 3'h1;
					if (st_ff.rxBit == 3'h7)
						nxt_st.rxSt = TSF_STOP;
				end
				else
					nxt_st.rxCnt = st_ff.rxCnt - 12'h1;
			TSF_STOP:
				if (st_ff.rxCnt == 12'h0)
				begin
					nxt_st.rxSt = TSF_IDLE;
					gotByte = st_ff.rxSync;
				end
				else
					nxt_st.rxCnt = st_ff.rxCnt - 12'h1;
			default:
				nxt_st.rxSt = TSF_IDLE;
		endcase

		// ----------------------------------------
		// Line framing and check
		// ----------------------------------------
		if (gotByte)
		begin
			if (newByte == `TSF_CHR_LF || newByte == `TSF_CHR_CR)
			begin
				if (st_ff.lineLen != 8'h0)
				begin
					if (st_ff.commaCnt == 2'h0 || st_ff.lineLen < 8'h3)
						nxt_st.frameError = 1'b1;
					else if (!hHi[4] || !hLo[4] || {hHi[3:0], hLo[3:0]} != st_ff.crcAt2)
						nxt_st.crcError = 1'b1;
					else
					begin
						nxt_st.rxEnd = 1'b1;
						// Lone query field, then comma and hex pair
						if (st_ff.queryField && st_ff.afterFirst == 8'h4 && st_ff.commaCnt == 2'h2)
						begin
							if (st_ff.name == pollName)
							begin
								nxt_st.requestSeen = 1'b1;
								nxt_st.requestName = st_ff.name;
								nxt_st.reqPend = 1'b1;
								nxt_st.reqName = st_ff.name;
							end
						end
					end
				end
				nxt_st.rxCrc = `TSF_CRC_INIT;
				nxt_st.crcAt1 = `TSF_CRC_INIT;
				nxt_st.crcAt2 = `TSF_CRC_INIT;
				nxt_st.lineLen = 8'h0;
				nxt_st.commaCnt = 2'h0;
				nxt_st.inName = 1'b1;
				nxt_st.name = '0;
				nxt_st.afterFirst = 8'h0;
				nxt_st.queryField = 1'b0;
			end
			else
			begin
				nxt_st.crcAt2 = st_ff.crcAt1;
				nxt_st.crcAt1 = st_ff.rxCrc;
				nxt_st.rxCrc = crcStep(st_ff.rxCrc, newByte);
				nxt_st.prev2 = st_ff.prev1;
				nxt_st.prev1 = newByte;
				if (st_ff.lineLen != 8'hff)
					nxt_st.lineLen = st_ff.lineLen + 8'h1;
				nxt_st.rxByte = newByte;
				nxt_st.rxValid = 1'b1;
				if (newByte == `TSF_CHR_COMMA)
				begin
					nxt_st.inName = 1'b0;
					if (st_ff.commaCnt != 2'h3)
						nxt_st.commaCnt = st_ff.commaCnt + 2'h1;
				end
				else if (st_ff.inName)
					nxt_st.name = {st_ff.name[15:0], newByte};
				if (!st_ff.inName && st_ff.afterFirst != 8'hff)
					nxt_st.afterFirst = st_ff.afterFirst + 8'h1;
				if (!st_ff.inName && st_ff.afterFirst == 8'h0)
					nxt_st.queryField = (newByte == `TSF_CHR_QUERY);
			end
		end

		// ----------------------------------------
		// Periodic timer
		// ----------------------------------------
		// Periodic sentence tick
		if (st_ff.perCnt == 32'h0)
		begin
			nxt_st.perCnt = `TSF_PERIOD_CYC - 32'h1;
			nxt_st.periodicTick = 1'b1;
		end
		else
			nxt_st.perCnt = st_ff.perCnt - 32'h1;

		// ----------------------------------------
		// Transmit sequencer and UART
		// ----------------------------------------
		if (st_ff.txSt == TSF_IDLE && !st_ff.txLine)
		begin
			unique case (st_ff.seq)
				TSF_TX_IDLE, TSF_TX_BODY:
					if (st_ff.bufCnt != 2'h0)
					begin
						nxt_st.txShift = {st_ff.buf0, 1'b0};
						nxt_st.txLine = 1'b1;
						nxt_st.txCrc = crcStep(st_ff.txCrc, st_ff.buf0);
						nxt_st.seq = st_ff.bufL0 ? TSF_TX_HI : TSF_TX_BODY;
						nxt_st.buf0 = st_ff.buf1;
						nxt_st.bufL0 = st_ff.bufL1;
						nxt_st.bufCnt = st_ff.bufCnt - 2'h1;
					end
				TSF_TX_HI:
				begin
					nxt_st.txShift = {hexChr(st_ff.txCrc[7:4]), 1'b0};
					nxt_st.txLine = 1'b1;
					nxt_st.seq = TSF_TX_LO;
				end
				TSF_TX_LO:
				begin
					nxt_st.txShift = {hexChr(st_ff.txCrc[3:0]), 1'b0};
					nxt_st.txLine = 1'b1;
					nxt_st.seq = TSF_TX_CR;
				end
				TSF_TX_CR:
				begin
					nxt_st.txShift = {`TSF_CHR_CR, 1'b0};
					nxt_st.txLine = 1'b1;
					nxt_st.seq = TSF_TX_LF;
				end
				TSF_TX_LF:
				begin
					nxt_st.txShift = {`TSF_CHR_LF, 1'b0};
					nxt_st.txLine = 1'b1;
					nxt_st.seq = TSF_TX_IDLE;
					nxt_st.txCrc = `TSF_CRC_INIT;
				end
				default:
					nxt_st.seq = TSF_TX_IDLE;
			endcase
		end
		if (st_ff.txLine)
		begin
			nxt_st.txLine = 1'b0;
			nxt_st.txSt = TSF_START;
			nxt_st.txBit = 3'h0;
			// Start bit shows since the load, so one cycle less here
			nxt_st.txCnt = 12'(`TSF_BIT_CYC - 2);
		end
		else if (st_ff.txSt != TSF_IDLE)
		begin
			if (st_ff.txCnt != 12'h0)
				nxt_st.txCnt = st_ff.txCnt - 12'h1;
			else if (st_ff.txSt == TSF_STOP)
				nxt_st.txSt = TSF_IDLE;
			else
			begin
				// Nine shifts: data bits, then the stop bit
				nxt_st.txShift = {1'b1, st_ff.txShift[8:1]};
				nxt_st.txCnt = 12'(`TSF_BIT_CYC - 1);
				if (st_ff.txSt == TSF_START)
					nxt_st.txSt = TSF_DATA;
				else
				begin
					nxt_st.txBit = st_ff.txBit + 3'h1;
					if (st_ff.txBit == 3'h7)
						nxt_st.txSt = TSF_STOP;
				end
			end
		end

		// Buffer fill after drain so both may happen in one cycle
		if (txValid && st_ff.txReady)
		begin
			if (nxt_st.bufCnt == 2'h0)
			begin
				nxt_st.buf0 = txByte;
				nxt_st.bufL0 = txLast;
			end
			else
			begin
				nxt_st.buf1 = txByte;
				nxt_st.bufL1 = txLast;
			end
			nxt_st.bufCnt = nxt_st.bufCnt + 2'h1;
		end
		// Room flag follows this cycle's drain and fill
		nxt_st.txReady = (nxt_st.bufCnt != 2'h2);
		// New request wins over the clear
		if (st_ff.reqPend && st_ff.seq == TSF_TX_IDLE && !nxt_st.requestSeen)
			nxt_st.reqPend = 1'b0;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			st_ff <= '0;
			st_ff.rxMeta <= 1'b1;
			st_ff.rxSync <= 1'b1;
			st_ff.txShift <= 9'h1ff;
			st_ff.inName <= 1'b1;
			st_ff.perCnt <= `TSF_PERIOD_CYC - 32'h1;
		end
		else
			st_ff <= nxt_st;
	end

	assign link.devToHost = st_ff.txShift[0];
	assign txReady = st_ff.txReady;
	assign requestSeen = st_ff.requestSeen;
	assign requestName = st_ff.requestName;
	assign periodicTick = st_ff.periodicTick;
	assign frameError = st_ff.frameError;
	assign crcError = st_ff.crcError;
	assign rxByte = st_ff.rxByte;
	assign rxValid = st_ff.rxValid;
	assign rxEnd = st_ff.rxEnd;
endmodule : tsf_device
`default_nettype wire

// >>> tsf_host.sv
`include "tsf_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tsf_host
(
	// System
	input wire logic clock,
	input wire logic rst,
	// Link
	tsf_link_if.hostEnd link,
	// Sentence to send: body is name, fields and final comma
	input wire tsf_pkg::tsf_byte_type txByte,
	input wire logic txValid,
	input wire logic txLast,
	output logic txReady,
	// Received line, checked
	output tsf_pkg::tsf_byte_type rxByte,
	output logic rxValid,
	output logic rxEnd,
	output logic crcError,
	output logic frameError
);
	import tsf_pkg::*;

	function automatic tsf_byte_type crcStep(input tsf_byte_type c, input tsf_byte_type d);
		tsf_byte_type r;
		logic fb;
		r = c;
		for (int i = 0; i < `TSF_DATA_BITS; i++)
		begin
			fb = r[0] ^ d[i];
			if (fb)
				r = r ^ `TSF_CRC_POLY;
			r = (r >> 1) & `TSF_CRC_MASK;
			if (fb)
				r = r | `TSF_CRC_TOP;
		end
		return r;
	endfunction : crcStep

	function automatic tsf_byte_type hexChr(input logic [3:0] n);
		return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction : hexChr

	function automatic logic [4:0] hexVal(input tsf_byte_type c);
		if (c >= 8'h30 && c <= 8'h39)
			return {1'b1, c[3:0]};
		if (c >= 8'h41 && c <= 8'h46)
			return {1'b1, c[3:0] + 4'h9};
		return 5'h00;
	endfunction : hexVal

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		logic rxMeta;
		logic rxSync;
		tsf_uart_type rxSt;
		logic [11:0] rxCnt;
		logic [2:0] rxBit;
		tsf_byte_type rxShift;
		tsf_byte_type rxCrc;
		tsf_byte_type prev1;
		tsf_byte_type prev2;
		tsf_byte_type crcAt1;
		tsf_byte_type crcAt2;
		logic [7:0] lineLen;
		logic sawComma;
		tsf_uart_type txSt;
		logic [11:0] txCnt;
		logic [2:0] txBit;
		logic [8:0] txShift;
		tsf_txseq_type seq;
		tsf_byte_type txCrc;
		logic txReady;
		tsf_byte_type rxByte;
		logic rxValid;
		logic rxEnd;
		logic crcError;
		logic frameError;
	} tsf_host_type;

	tsf_host_type st_ff;
	tsf_host_type nxt_st;
	logic [4:0] hHi;
	logic [4:0] hLo;
	logic gotByte;

	always_comb
	begin
		nxt_st = st_ff;
		gotByte = 1'b0;
		hHi = hexVal(st_ff.prev2);
		hLo = hexVal(st_ff.prev1);
		nxt_st.rxMeta = link.devToHost;
		nxt_st.rxSync = st_ff.rxMeta;
		nxt_st.rxValid = 1'b0;
		nxt_st.rxEnd = 1'b0;
		nxt_st.crcError = 1'b0;
		nxt_st.frameError = 1'b0;
		nxt_st.txReady = 1'b0;

		unique case (st_ff.rxSt)
			TSF_IDLE:
				if (!st_ff.rxSync)
				begin
					nxt_st.rxSt = TSF_START;
					nxt_st.rxCnt = 12'(`TSF_HALF_CYC);
				end
			TSF_START:
				if (st_ff.rxCnt == 12'h0)
				begin
					nxt_st.rxSt = st_ff.rxSync ? TSF_IDLE : TSF_DATA;
					nxt_st.rxCnt = 12'(`TSF_BIT_CYC - 1);
					nxt_st.rxBit = 3'h0;
				end
				else
					nxt_st.rxCnt = st_ff.rxCnt - 12'h1;
			TSF_DATA:
				if (st_ff.rxCnt == 12'h0)
				begin
					nxt_st.rxShift = {st_ff.rxSync, st_ff.rxShift[7:1]};
					nxt_st.rxCnt = 12'(`TSF_BIT_CYC - 1);
					nxt_st.rxBit = st_ff.rxBit + 3'h1;
					if (st_ff.rxBit == 3'h7)
						nxt_st.rxSt = TSF_STOP;
				end
				else
					nxt_st.rxCnt = st_ff.rxCnt - 12'h1;
			TSF_STOP:
				if (st_ff.rxCnt == 12'h0)
				begin
					nxt_st.rxSt = TSF_IDLE;
					gotByte = st_ff.rxSync;
				end
				else
					nxt_st.rxCnt = st_ff.rxCnt - 12'h1;
			default:
				nxt_st.rxSt = TSF_IDLE;
		endcase

		if (gotByte)
		begin
			if (st_ff.rxShift == `TSF_CHR_LF || st_ff.rxShift == `TSF_CHR_CR)
			begin
				if (st_ff.lineLen != 8'h0)
				begin
					if (!st_ff.sawComma || st_ff.lineLen < 8'h3)
						nxt_st.frameError = 1'b1;
					else if (!hHi[4] || !hLo[4] || {hHi[3:0], hLo[3:0]} != st_ff.crcAt2)
						nxt_st.crcError = 1'b1;
					else
						nxt_st.rxEnd = 1'b1;
				end
				nxt_st.rxCrc = `TSF_CRC_INIT;
				nxt_st.crcAt1 = `TSF_CRC_INIT;
				nxt_st.crcAt2 = `TSF_CRC_INIT;
				nxt_st.lineLen = 8'h0;
				nxt_st.sawComma = 1'b0;
			end
			else
			begin
				nxt_st.crcAt2 = st_ff.crcAt1;
				nxt_st.crcAt1 = st_ff.rxCrc;
				nxt_st.rxCrc = crcStep(st_ff.rxCrc, st_ff.rxShift);
				nxt_st.prev2 = st_ff.prev1;
				nxt_st.prev1 = st_ff.rxShift;
				if (st_ff.lineLen != 8'hff)
					nxt_st.lineLen = st_ff.lineLen + 8'h1;
				if (st_ff.rxShift == `TSF_CHR_COMMA)
					nxt_st.sawComma = 1'b1;
				nxt_st.rxByte = st_ff.rxShift;
				nxt_st.rxValid = 1'b1;
			end
		end

		// Transmit: sentence body, then CRC pair, CR, LF
		if (st_ff.txSt == TSF_IDLE)
		begin
			unique case (st_ff.seq)
				TSF_TX_IDLE, TSF_TX_BODY:
					if (txValid)
					begin
						nxt_st.txReady = 1'b1;
						nxt_st.txShift = {txByte, 1'b0};
						nxt_st.txCrc = crcStep(st_ff.txCrc, txByte);
						nxt_st.seq = txLast ? TSF_TX_HI : TSF_TX_BODY;
					end
				TSF_TX_HI:
				begin
					nxt_st.txShift = {hexChr(st_ff.txCrc[7:4]), 1'b0};
					nxt_st.seq = TSF_TX_LO;
				end
				TSF_TX_LO:
				begin
					nxt_st.txShift = {hexChr(st_ff.txCrc[3:0]), 1'b0};
					nxt_st.seq = TSF_TX_CR;
				end
				TSF_TX_CR:
				begin
					nxt_st.txShift = {`TSF_CHR_CR, 1'b0};
					nxt_st.seq = TSF_TX_LF;
				end
				TSF_TX_LF:
				begin
					nxt_st.txShift = {`TSF_CHR_LF, 1'b0};
					nxt_st.seq = TSF_TX_IDLE;
					nxt_st.txCrc = `TSF_CRC_INIT;
				end
				default:
					nxt_st.seq = TSF_TX_IDLE;
			endcase
			if (nxt_st.txShift[0] == 1'b0)
			begin
				nxt_st.txSt = TSF_START;
				nxt_st.txBit = 3'h0;
				nxt_st.txCnt = 12'(`TSF_BIT_CYC - 1);
			end
		end
		else if (st_ff.txCnt != 12'h0)
			nxt_st.txCnt = st_ff.txCnt - 12'h1;
		else if (st_ff.txSt == TSF_STOP)
			nxt_st.txSt = TSF_IDLE;
		else
		begin
			// Nine shifts: data bits, then the stop bit
			nxt_st.txShift = {1'b1, st_ff.txShift[8:1]};
			nxt_st.txCnt = 12'(`TSF_BIT_CYC - 1);
			if (st_ff.txSt == TSF_START)
				nxt_st.txSt = TSF_DATA;
			else
			begin
				nxt_st.txBit = st_ff.txBit + 3'h1;
				if (st_ff.txBit == 3'h7)
					nxt_st.txSt = TSF_STOP;
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			st_ff <= '0;
			st_ff.rxMeta <= 1'b1;
			st_ff.rxSync <= 1'b1;
			st_ff.txShift <= 9'h1ff;
		end
		else
			st_ff <= nxt_st;
	end

	assign link.hostToDev = st_ff.txShift[0];
	assign txReady = st_ff.txReady;
	assign rxByte = st_ff.rxByte;
	assign rxValid = st_ff.rxValid;
	assign rxEnd = st_ff.rxEnd;
	assign crcError = st_ff.crcError;
	assign frameError = st_ff.frameError;
endmodule : tsf_host
`default_nettype wire

// >>> tsf_link_sva.sv
`include "tsf_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tsf_link_sva
(
	// System
	input wire logic clock,
	input wire logic rst,
	// Link
	input wire logic devToHost,
	input wire logic hostToDev
);
	import tsf_pkg::*;
	localparam int BIT = `TSF_BIT_CYC;
	localparam int TOL = 3;
	localparam int MAXLOW = 9 * BIT + TOL;
	typedef struct packed
	{
		logic devLvl;
		logic hostLvl;
		logic [15:0] devRun;
		logic [15:0] hostRun;
	} tsf_sva_type;
	tsf_sva_type st_ff;
	tsf_sva_type nxt_st;
	// ----------------------------------------
	// Run length of each line level
	// ----------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.devLvl = devToHost;
		nxt_st.hostLvl = hostToDev;
		if (devToHost != st_ff.devLvl)
			nxt_st.devRun = 16'h0001;
		else if (st_ff.devRun != 16'hffff)
			nxt_st.devRun = st_ff.devRun + 16'h0001;
		if (hostToDev != st_ff.hostLvl)
			nxt_st.hostRun = 16'h0001;
		else if (st_ff.hostRun != 16'hffff)
			nxt_st.hostRun = st_ff.hostRun + 16'h0001;
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			st_ff <= '{devLvl: 1'b1, hostLvl: 1'b1, devRun: 16'hffff, hostRun: 16'hffff};
		else
			st_ff <= nxt_st;
	end
	function automatic logic onGrid(input logic [15:0] r);
		int m;
		m = r % BIT;
		return (m <= TOL) || (m >= BIT - TOL);
	endfunction : onGrid
	// ----------------------------------------
	// Line timing
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence devFrameStart;
		devToHost ##1 !devToHost;
	endsequence
	sequence hostFrameStart;
		hostToDev ##1 !hostToDev;
	endsequence
	chk_idle_release: assert property ($fell(rst) |-> devToHost && hostToDev)
		else $error("line not idle after reset");
	chk_dev_start_bit: assert property (devFrameStart |=> !devToHost [*8])
		else $error("device start bit too short");
	chk_host_start_bit: assert property (hostFrameStart |=> !hostToDev [*8])
		else $error("host start bit too short");
	chk_dev_bit_grid: assert property ($rose(devToHost) |-> onGrid(st_ff.devRun))
		else $error("device low run off bit grid");
	chk_host_bit_grid: assert property ($rose(hostToDev) |-> onGrid(st_ff.hostRun))
		else $error("host low run off bit grid");
	chk_dev_low_max: assert property ($rose(devToHost) |-> st_ff.devRun <= MAXLOW)
		else $error("device low run over nine bits");
	chk_host_low_max: assert property ($rose(hostToDev) |-> st_ff.hostRun <= MAXLOW)
		else $error("host low run over nine bits");
	chk_dev_stop_min: assert property ($fell(devToHost) |-> st_ff.devRun >= BIT - TOL)
		else $error("device high run under one bit");
	chk_host_stop_min: assert property ($fell(hostToDev) |-> st_ff.hostRun >= BIT - TOL)
		else $error("host high run under one bit");
endmodule : tsf_link_sva
`default_nettype wire

// >>> text_sentence_framer_crc8_bench.sv
`include "tsf_map.svh"
`timescale 1ns/1ns
`default_nettype none
module text_sentence_framer_crc8_bench;
	import tsf_pkg::*;
	localparam int BIT = `TSF_BIT_CYC;
	// Four sentences plus fault lines need about 543000 cycles
	localparam int LIMIT = 700000;
	logic clock, rst, rawLine, stall;
	tsf_byte_type dTxByte, hTxByte, dRxByte, hRxByte;
	logic dTxValid, dTxLast, dTxReady, hTxValid, hTxLast, hTxReady;
	tsf_name_type pollName, reqName;
	logic dReq, dTick, dFrm, dCrc, dRxValid, dRxEnd, hRxValid, hRxEnd, hCrc, hFrm;
	logic d2Req, d2Frm, d2Crc, d2End;
	logic [31:0] nErrors, samplesChecked, cyc;
	logic [31:0] ev [10];
	tsf_byte_type qs [4][$];
	tsf_link_if link();
	tsf_link_if link2();
	assign link2.hostToDev = rawLine;
	tsf_device tsf_device_i (.clock(clock), .rst(rst), .link(link), .txByte(dTxByte),
		.txValid(dTxValid), .txLast(dTxLast), .txReady(dTxReady), .pollName(pollName),
		.requestSeen(dReq), .requestName(reqName), .periodicTick(dTick), .frameError(dFrm),
		.crcError(dCrc), .rxByte(dRxByte), .rxValid(dRxValid), .rxEnd(dRxEnd));
	tsf_host tsf_host_i (.clock(clock), .rst(rst), .link(link), .txByte(hTxByte),
		.txValid(hTxValid), .txLast(hTxLast), .txReady(hTxReady), .rxByte(hRxByte),
		.rxValid(hRxValid), .rxEnd(hRxEnd), .crcError(hCrc), .frameError(hFrm));
	tsf_device tsf_device_i2 (.clock(clock), .rst(rst), .link(link2), .txByte(8'h00),
		.txValid(1'b0), .txLast(1'b0), .txReady(), .pollName(pollName), .requestSeen(d2Req),
		.requestName(), .periodicTick(), .frameError(d2Frm), .crcError(d2Crc), .rxByte(),
		.rxValid(), .rxEnd(d2End));
	tsf_link_sva tsf_link_sva_i (.clock(clock), .rst(rst), .devToHost(link.devToHost),
		.hostToDev(link.hostToDev));
	always #4 clock = ~clock;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic lineOf(input int w);
		return w ? link.hostToDev : link.devToHost;
	endfunction : lineOf
	function automatic logic [7:0] hexc(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
	endfunction : hexc
	function automatic string frame(input string s, input bit bad);
		logic [7:0] c, d;
		logic fb;
		string h;
		c = 8'h00;
		for (int i = 0; i < s.len(); i++)
		begin
			d = s[i];
			for (int j = 0; j < 8; j++)
			begin
				fb = c[0] ^ d[0];
				if (fb)
					c = c ^ 8'h18;
				c = (c >> 1) & 8'h7f;
				if (fb)
					c = c | 8'h80;
				d = d >> 1;
			end
		end
		c = bad ? ~c : c;
		h = "00";
		h[0] = hexc(c[7:4]);
		h[1] = hexc(c[3:0]);
		return {s, h};
	endfunction : frame
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked = samplesChecked + 1;
		if (got !== exp)
		begin
			nErrors = nErrors + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wrapUp();
		$display("checks %0d errors %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrapUp
	task automatic send(input bit h, input string s);
		int n;
		for (int i = 0; i < s.len(); i++)
		begin
			if (h)
			begin
				hTxByte <= s[i];
				hTxValid <= 1'b1;
				hTxLast <= (i == s.len() - 1);
			end
			else
			begin
				dTxByte <= s[i];
				dTxValid <= 1'b1;
				dTxLast <= (i == s.len() - 1);
			end
			n = 0;
			@(negedge clock);
			while ((h ? hTxReady : dTxReady) !== 1'b1 && n < LIMIT)
			begin
				@(negedge clock);
				n++;
			end
			@(posedge clock);
		end
		if (h)
		begin
			hTxValid <= 1'b0;
			hTxLast <= 1'b0;
		end
		else
		begin
			dTxValid <= 1'b0;
			dTxLast <= 1'b0;
		end
	endtask : send
	task automatic rawSend(input string s, input logic [7:0] term);
		logic [7:0] b;
		for (int i = 0; i <= s.len(); i++)
		begin
			b = (i == s.len()) ? term : s[i];
			for (int j = 0; j < 10; j++)
			begin
				rawLine <= (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : b[j - 1];
				repeat (BIT) @(posedge clock);
			end
		end
	endtask : rawSend
	task automatic wireRx(input int w);
		logic [7:0] b;
		do @(posedge clock); while (lineOf(w) !== 1'b0 || rst);
		repeat (BIT / 2) @(posedge clock);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge clock);
			b[i] = lineOf(w);
		end
		repeat (BIT) @(posedge clock);
		qs[w].push_back(b);
	endtask : wireRx
	task automatic cmpq(input int w, input string e, input bit eol);
		logic [7:0] x [$];
		for (int i = 0; i < e.len(); i++)
			x.push_back(e[i]);
		if (eol)
			x = {x, 8'h0d, 8'h0a};
		check(qs[w].size(), x.size());
		foreach (x[i])
			if (qs[w].size() > 0)
				check(qs[w].pop_front(), x[i]);
	endtask : cmpq
	task automatic waitFor(input int k, input int n, input int w);
		int t;
		t = 0;
		while ((w < 0 ? ev[k] < n : qs[w].size() < n) && t < LIMIT)
		begin
			@(posedge clock);
			t++;
		end
	endtask : waitFor
	task automatic cmpEv(input logic [31:0] e [10]);
		foreach (e[i])
			check(ev[i], e[i]);
	endtask : cmpEv
	always wireRx(0);
	always wireRx(1);
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (hRxValid === 1'b1)
			qs[2].push_back(hRxByte);
		if (dRxValid === 1'b1)
			qs[3].push_back(dRxByte);
		ev[0] = ev[0] + (dRxEnd === 1'b1);
		ev[1] = ev[1] + (dReq === 1'b1);
		ev[2] = ev[2] + ((dCrc | dFrm) === 1'b1);
		ev[3] = ev[3] + (hRxEnd === 1'b1);
		ev[4] = ev[4] + (hCrc === 1'b1);
		ev[5] = ev[5] + (hFrm === 1'b1);
		ev[6] = ev[6] + (d2Crc === 1'b1);
		ev[7] = ev[7] + (d2Frm === 1'b1);
		ev[8] = ev[8] + ((d2End | d2Req) === 1'b1);
		ev[9] = ev[9] + (dTick === 1'b1);
		if (!rst && dTxValid && dTxReady === 1'b0)
			stall = 1'b1;
		if (cyc == LIMIT)
		begin
			nErrors = nErrors + 1;
			wrapUp();
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		clock = 1'b0;
		rst = 1'b1;
		rawLine = 1'b1;
		stall = 1'b0;
		{dTxByte, hTxByte, dTxValid, dTxLast, hTxValid, hTxLast} = '0;
		pollName = "VR1";
		{nErrors, samplesChecked, cyc} = '0;
		foreach (ev[i])
			ev[i] = 32'h0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		fork
			send(1'b1, "VR1,?,");
			send(1'b0, "ST1,A,");
			begin
				rawSend(frame("XYZ", 1'b0), 8'h0d);
				rawSend(frame("VR1,?,", 1'b1), 8'h0a);
			end
		join
		waitFor(6, 1, -1);
		waitFor(0, 1, -1);
		waitFor(3, 1, -1);
		waitFor(0, 10, 0);
		cmpq(1, frame("VR1,?,", 1'b0), 1'b1);
		cmpq(0, frame("ST1,A,", 1'b0), 1'b1);
		cmpq(3, frame("VR1,?,", 1'b0), 1'b0);
		cmpq(2, frame("ST1,A,", 1'b0), 1'b0);
		check(reqName, "VR1");
		check(stall, 1'b1);
		cmpEv('{1, 1, 0, 1, 0, 0, 1, 1, 0, 0});
		$display("test 1 done");
		fork
			send(1'b1, "BB2,?,");
			send(1'b0, "AB");
		join
		waitFor(0, 2, -1);
		waitFor(5, 1, -1);
		waitFor(0, 6, 0);
		waitFor(0, 10, 1);
		cmpq(1, frame("BB2,?,", 1'b0), 1'b1);
		cmpq(0, frame("AB", 1'b0), 1'b1);
		cmpq(3, frame("BB2,?,", 1'b0), 1'b0);
		cmpq(2, frame("AB", 1'b0), 1'b0);
		cmpEv('{2, 1, 0, 1, 0, 1, 1, 1, 0, 0});
		check(reqName, "VR1");
		$display("test 2 done");
		wrapUp();
	end
endmodule : text_sentence_framer_crc8_bench
`default_nettype wire
